// ===== verilog/rss_sequencer.sv
// Reset sources combiner and start-up sequencer.
// Assumes analog POR/brown-out outputs and the pin are synchronous-ish levels;
// the pin is resynchronised anyway. Flags are written by software via ports.
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int POWERUP_TIMER_CYC = POWERUP_TIMER_CYC_64
) (
  input  wire logic       clk,                   // 20 MHz system clock
  input  wire logic       reset,                 // Synchronous reset, active high
  input  wire logic       porActive,             // Analog power-on reset active
  input  wire logic       progModeExit,          // Pulse: leaving programming mode
  input  wire logic [1:0] brownoutModeSel,       // Brown-out mode field
  input  wire logic       swBrownoutEnableWr,    // Pulse: write software enable
  input  wire logic       swBrownoutEnableIn,    // Value for software enable
  input  wire logic       detectorReady,         // Analog detector warmed up
  input  wire logic       supplyBelow,           // Supply below brown-out level
  input  wire logic       sleepMode,             // Core is in sleep
  input  wire logic       powerupTimerSel,       // Power-up timer enabled
  input  wire logic       lowVoltageProgEnable,  // Low-voltage programming bit
  input  wire logic       pinResetEnable,        // Pin-reset enable bit
  input  wire logic       extResetPinIn,         // Reset pin level, active low
  input  wire logic       swPullupEnable,        // Software pull-up control
  input  wire logic       watchdogTimeout,       // Pulse: watchdog expired
  input  wire logic       watchdogClearInstr,    // Pulse: watchdog clear executed
  input  wire logic       sleepInstr,            // Pulse: sleep executed
  input  wire logic       resetInstr,            // Pulse: reset instruction
  input  wire logic       stackErrorResetEnable, // Stack error reset enable
  input  wire logic       stackOverflow,         // Pulse: stack overflow
  input  wire logic       stackUnderflow,        // Pulse: stack underflow
  input  wire logic       execViolation,         // Pulse: illegal fetch
  input  wire logic [7:0] flagWrData,            // Software data for cause flags
  input  wire logic       flagWr,                // Pulse: software flag write
  output logic            coreReset,             // Core reset, active high
  output logic            brownoutDetectorOn,    // Detector enable to analog
  output logic            swBrownoutEnable,      // Software enable bit readback
  output logic            brownoutReady,         // Detector ready status
  output logic            pinPullupOn,           // Weak pull-up on reset pin
  output logic            pinResetFunction,      // Pin works as reset input
  output logic            extResetPinOe,         // Pin output enable, never set
  output logic            brownoutCauseFlag,     // Low: brown-out happened
  output logic            pinResetCauseFlag,     // Low: pin reset happened
  output logic            instrResetCauseFlag,   // Low: reset instruction
  output logic            watchdogResetCauseFlag,// Low: watchdog reset
  output logic            stackOverflowFlag,     // High: stack overflow reset
  output logic            stackUnderflowFlag,    // High: stack underflow reset
  output logic            execViolationFlag,     // Low: execution violation
  output logic            timeoutFlag,           // Low: watchdog time-out
  output logic            powerdownFlag          // Low: sleep entered
);
  localparam int PW = $clog2(POWERUP_TIMER_CYC + 1);

  rss_state_t  state_reg;
  rss_state_t  state_next;
  logic [PW-1:0] powerup_timer_reg;
  logic [3:0]  delay_reg;
  logic        pinSync1_reg;
  logic        pinSync2_reg;
  logic        borFilt_reg;
  logic [7:0]  borCnt_reg;
  logic        borActive;
  logic        pinEnabled;
  logic        pinLow;
  logic        coldStart;
  logic        warmReset;
  logic        borLowLong;
  logic        swEn_reg;
  logic        protect;
  logic        startWait;
  rss_filter_if pinIf ();

  // Pin reset function enable
  assign pinEnabled = lowVoltageProgEnable | pinResetEnable;

  // Detector operating per mode
  always_comb begin
    case (brownoutModeSel)
      BOR_MODE_ON:    borActive = 1'b1;
      BOR_MODE_NOSLP: borActive = ~sleepMode;
      BOR_MODE_SW:    borActive = swEn_reg;
      default:        borActive = 1'b0;
    endcase
  end
  // Protection acts only once armed
  assign protect = borActive & detectorReady;

  // Start waits for ready and good supply in modes 11 and 10 only
  assign startWait = (brownoutModeSel == BOR_MODE_ON || brownoutModeSel == BOR_MODE_NOSLP)
                     & (~detectorReady | supplyBelow);

  // Software brown-out enable, ignored in effect outside mode 01
  always_ff @(posedge clk) begin
    if (reset || porActive || progModeExit) begin
      swEn_reg <= RST_SW_BOR_EN;
    end else if (swBrownoutEnableWr) begin
      swEn_reg <= swBrownoutEnableIn;
    end
  end

  // Brown-out filter: supply must stay low beyond the filter time
  always_ff @(posedge clk) begin
    if (reset || !protect || !supplyBelow) begin
      borCnt_reg <= 8'h00;
      borFilt_reg <= 1'b0;
    end else if (borCnt_reg >= 8'(BOR_FILTER_CYC)) begin
      borFilt_reg <= 1'b1;
    end else begin
      borCnt_reg <= borCnt_reg + 8'h01;
    end
  end
  assign borLowLong = borFilt_reg & supplyBelow;

  // Two-stage pin synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      pinSync1_reg <= 1'b1;
      pinSync2_reg <= 1'b1;
    end else begin
      pinSync1_reg <= extResetPinIn;
      pinSync2_reg <= pinSync1_reg;
    end
  end
  assign pinIf.rawIn = pinSync2_reg;

  // Noise filter on pin reset path
  rss_glitch_filter #(
    .CYCLES (PIN_FILTER_CYC),
    .INIT   (1'b1)
  ) uPinFilter (
    .clk   (clk),
    .reset (reset),
    .f     (pinIf)
  );
  assign pinLow = pinEnabled & ~pinIf.filtered;

  // Cold start: power-on, programming exit, or filtered brown-out
  assign coldStart = porActive | progModeExit | borLowLong;
  // Warm resets restart from the release delay path
  // A watchdog expiry during sleep only wakes the core; it is not a reset
  assign warmReset = (watchdogTimeout & ~sleepMode) | resetInstr | execViolation
                     | (stackErrorResetEnable & (stackOverflow | stackUnderflow));

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_POR:     state_next = ST_BORWAIT;
      ST_BORWAIT: if (!startWait) state_next = powerupTimerSel ? ST_POWERUP_TIMER : ST_PINWAIT;
      ST_POWERUP_TIMER:    if (powerup_timer_reg == '0) state_next = ST_PINWAIT;
      ST_PINWAIT: if (!pinLow) state_next = ST_DELAY;
      ST_DELAY:   if (delay_reg == 4'h0) state_next = ST_RUN;
      ST_RUN:     state_next = ST_RUN;
      default:    state_next = ST_POR;
    endcase
    if (coldStart) state_next = ST_POR;
    else if (warmReset || pinLow) state_next = ST_PINWAIT;
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Power-up timer, abandoned for the pin wait whenever the enabled reset pin is low
  always_ff @(posedge clk) begin
    if (reset || state_reg != ST_POWERUP_TIMER) begin
      powerup_timer_reg <= PW'(POWERUP_TIMER_CYC - 1);
    end else if (powerup_timer_reg != '0) begin
      powerup_timer_reg <= powerup_timer_reg - PW'(1);
    end
  end

  // Release delay counter
  always_ff @(posedge clk) begin
    if (reset || state_reg != ST_DELAY) begin
      delay_reg <= 4'(RELEASE_CYC - 1);
    end else if (delay_reg != 4'h0) begin
      delay_reg <= delay_reg - 4'h1;
    end
  end

  // Core reset, brown-out and pin outputs, all registered
  always_ff @(posedge clk) begin
    if (reset) begin
      coreReset <= 1'b1;
      brownoutDetectorOn <= 1'b0;
      swBrownoutEnable <= RST_SW_BOR_EN;
      brownoutReady <= 1'b0;
      pinPullupOn <= 1'b1;
      pinResetFunction <= 1'b1;
      extResetPinOe <= 1'b0;
    end else begin
      coreReset <= (state_next != ST_RUN);
      brownoutDetectorOn <= borActive;
      swBrownoutEnable <= swEn_reg;
      brownoutReady <= protect;
      pinPullupOn <= pinEnabled | swPullupEnable;
      pinResetFunction <= pinEnabled;
      extResetPinOe <= 1'b0;
    end
  end

  // Cause flags: hardware events win over software writes
  always_ff @(posedge clk) begin
    if (reset || porActive || progModeExit) begin
      brownoutCauseFlag <= 1'b0;
      pinResetCauseFlag <= RST_ACTIVE_LOW_FLAG;
      instrResetCauseFlag <= RST_ACTIVE_LOW_FLAG;
      watchdogResetCauseFlag <= RST_ACTIVE_LOW_FLAG;
      stackOverflowFlag <= RST_STACK_FLAG;
      stackUnderflowFlag <= RST_STACK_FLAG;
      execViolationFlag <= RST_ACTIVE_LOW_FLAG;
      timeoutFlag <= RST_ACTIVE_LOW_FLAG;
      powerdownFlag <= RST_ACTIVE_LOW_FLAG;
    end else begin
      if (flagWr) begin
        brownoutCauseFlag <= flagWrData[0];
        pinResetCauseFlag <= flagWrData[3];
        instrResetCauseFlag <= flagWrData[2];
        watchdogResetCauseFlag <= flagWrData[4];
        stackOverflowFlag <= flagWrData[7];
        stackUnderflowFlag <= flagWrData[6];
        execViolationFlag <= flagWrData[1];
      end
      if (borLowLong) begin
        brownoutCauseFlag <= 1'b0;
        pinResetCauseFlag <= 1'b1;
        instrResetCauseFlag <= 1'b1;
        stackOverflowFlag <= 1'b0;
        stackUnderflowFlag <= 1'b0;
        timeoutFlag <= 1'b1;
        powerdownFlag <= 1'b1;
      end
      if (pinLow && state_reg == ST_RUN) pinResetCauseFlag <= 1'b0;
      if (resetInstr) instrResetCauseFlag <= 1'b0;
      if (execViolation) execViolationFlag <= 1'b0;
      if (stackErrorResetEnable && stackOverflow) stackOverflowFlag <= 1'b1;
      if (stackErrorResetEnable && stackUnderflow) stackUnderflowFlag <= 1'b1;
      if (watchdogClearInstr) begin
        timeoutFlag <= 1'b1;
        powerdownFlag <= 1'b1;
      end
      if (sleepInstr) begin
        timeoutFlag <= 1'b1;
        powerdownFlag <= 1'b0;
      end
      if (watchdogTimeout) begin
        timeoutFlag <= 1'b0;
        watchdogResetCauseFlag <= sleepMode ? watchdogResetCauseFlag : 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/rss_pkg.sv
// Package for the reset sources and start-up sequencer.
// Assumes a 20 MHz system clock; timer and filter counts derive from that rate, RELEASE_CYC is fixed.
package rss_pkg;
  localparam int CLK_HZ = 20000000;
  // Brown-out mode field encodings
  localparam logic [1:0] BOR_MODE_OFF   = 2'h0;
  localparam logic [1:0] BOR_MODE_SW    = 2'h1;
  localparam logic [1:0] BOR_MODE_NOSLP = 2'h2;
  localparam logic [1:0] BOR_MODE_ON    = 2'h3;
  // Power-up timer: longest period in ms, and its cycle count
  localparam int POWERUP_TIMER_MAX_MS    = 64;
  localparam int POWERUP_TIMER_CYC_64    = (CLK_HZ / 1000) * POWERUP_TIMER_MAX_MS;
  // Release delay after the pin goes high
  localparam int RELEASE_CYC    = 10;
  // Brown-out filter time (ns) and pin noise filter time (ns)
  localparam int BOR_FILTER_NS  = 1000;
  localparam int BOR_FILTER_CYC = (BOR_FILTER_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int PIN_FILTER_NS  = 200;
  localparam int PIN_FILTER_CYC = (PIN_FILTER_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Reset values of cause flags and software brown-out enable after power-on
  localparam logic RST_ACTIVE_LOW_FLAG = 1'b1;
  localparam logic RST_STACK_FLAG      = 1'b0;
  localparam logic RST_SW_BOR_EN       = 1'b1;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_POR, ST_BORWAIT, ST_POWERUP_TIMER, ST_PINWAIT, ST_DELAY, ST_RUN
  } rss_state_t;
endpackage

// ===== verilog/rss_filter_if.sv
// Interface between the sequencer and its glitch filter.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface rss_filter_if;
  logic rawIn;     // Level to be filtered
  logic filtered;  // Level held stable for the filter time
  modport owner  (output rawIn, input filtered);
  modport filter (input rawIn, output filtered);
endinterface
`default_nettype wire

// ===== verilog/rss_glitch_filter.sv
// Glitch filter: output follows input only after it has been stable.
// Assumes input already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rss_glitch_filter #(
  parameter int CYCLES = 4,
  parameter logic INIT = 1'b1
) (
  input  wire logic clk,            // System clock
  input  wire logic reset,          // Synchronous reset
  rss_filter_if.filter f            // Filter link
);
  logic [15:0] cnt_reg;
  logic        out_reg;
  // Count stable cycles differing from output, then follow
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= 16'h0000;
      out_reg <= INIT;
    end else if (f.rawIn == out_reg) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg >= 16'(CYCLES - 1)) begin
      cnt_reg <= 16'h0000;
      out_reg <= f.rawIn;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  assign f.filtered = out_reg;
endmodule
`default_nettype wire

// ===== test/rss_sequencer_checker.sv
// Checker for the reset sequencer, bound to its top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_checker
  import rss_pkg::*;
(
  input wire logic clk, reset, porActive, lowVoltageProgEnable, pinResetEnable,
  input wire logic swPullupEnable, extResetPinIn, detectorReady, sleepMode,
  input wire logic watchdogTimeout, resetInstr, stackOverflow, stackErrorResetEnable,
  input wire logic execViolation, coreReset, brownoutDetectorOn, brownoutReady,
  input wire logic pinPullupOn, pinResetFunction, extResetPinOe, watchdogResetCauseFlag,
  input wire logic timeoutFlag, instrResetCauseFlag, stackOverflowFlag, execViolationFlag,
  input wire logic [1:0] brownoutModeSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Pin, pull-up and release checks
  a_pin_never_driven: assert property (!extResetPinOe)
    else $error("reset pin output enabled");
  a_pin_func_on: assert property ((lowVoltageProgEnable || pinResetEnable)[*3] |-> pinResetFunction)
    else $error("pin reset function off while enabled");
  a_pin_func_off: assert property ((!lowVoltageProgEnable && !pinResetEnable && !swPullupEnable)[*3]
    |-> !pinResetFunction && !pinPullupOn) else $error("pin function or pull-up left on");
  a_pin_holds_core: assert property ((pinResetFunction && !extResetPinIn)[*8] |=> coreReset)
    else $error("low pin did not hold reset");
  a_release_gap: assert property ($fell(coreReset) && pinResetFunction |-> $past(extResetPinIn, 10))
    else $error("core released too soon after pin");
  // Warm reset sources and their flags
  a_wdt_resets: assert property (watchdogTimeout && !sleepMode |-> ##[1:4]
    (coreReset && !watchdogResetCauseFlag && !timeoutFlag)) else $error("watchdog reset wrong");
  a_instr_resets: assert property (resetInstr |-> ##[1:4] (coreReset && !instrResetCauseFlag))
    else $error("reset instruction wrong");
  a_stack_resets: assert property (stackOverflow && stackErrorResetEnable |=> ##[0:3]
    (coreReset && stackOverflowFlag)) else $error("stack reset wrong");
  a_exec_resets: assert property (execViolation |=> ##[0:3] (coreReset && !execViolationFlag))
    else $error("violation reset wrong");
  // Brown-out detector control
  a_off_mode_idle: assert property ((brownoutModeSel == BOR_MODE_OFF)[*3] |-> !brownoutDetectorOn)
    else $error("detector on in off mode");
  a_on_mode_armed: assert property ((brownoutModeSel == BOR_MODE_ON && !porActive)[*3]
    |-> brownoutDetectorOn) else $error("detector off in always-on mode");
  a_ready_follows: assert property (brownoutReady |-> $past(detectorReady))
    else $error("ready without detector ready");
  c_release: cover property ($fell(coreReset));
  c_wdt: cover property (watchdogTimeout ##1 coreReset);
  c_pin_low: cover property ((pinResetFunction && !extResetPinIn)[*8]);
endmodule
bind rss_sequencer rss_sequencer_checker u_chk (.clk, .reset, .porActive,
  .lowVoltageProgEnable, .pinResetEnable, .swPullupEnable, .extResetPinIn, .detectorReady,
  .sleepMode, .watchdogTimeout, .resetInstr, .stackOverflow, .stackErrorResetEnable,
  .execViolation, .coreReset, .brownoutDetectorOn, .brownoutReady, .pinPullupOn,
  .pinResetFunction, .extResetPinOe, .watchdogResetCauseFlag, .timeoutFlag,
  .instrResetCauseFlag, .stackOverflowFlag, .execViolationFlag, .brownoutModeSel);
`default_nettype wire

// ===== test/rss_supply_model.sv
// Model of the supply monitors and the external reset pin driver.
// Assumes the bench gives requests as levels at falling edges; outputs change at rising edges.
`timescale 1ns/1ps
`default_nettype none
module rss_supply_model #(
  parameter int WARM_CYC = 8
) (
  input  wire logic clk, porReq, dipReq, pinLowReq, detectorOn, pullupOn, // Requests
  output logic      porActive, detectorReady, supplyBelow, extResetPinIn  // To the block
);
  int warm = 0;
  initial {porActive, detectorReady, supplyBelow, extResetPinIn} = 4'h9;
  // Supply level and detector warm-up; ready drops as soon as it is off
  always @(posedge clk) begin
    porActive <= porReq;
    supplyBelow <= porReq | dipReq;
    warm <= detectorOn ? ((warm < WARM_CYC) ? warm + 1 : warm) : 0;
    detectorReady <= detectorOn && (warm >= WARM_CYC);
  end
  // Pin driven low on request, else pulled up, else floating and changing
  always @(posedge clk)
    extResetPinIn <= pinLowReq ? 1'b0 : (pullupOn ? 1'b1 : ~extResetPinIn);
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the reset sequencer with a shortened power-up timer.
// Assumes the supply and pin model in rss_supply_model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rss_pkg::*;
  localparam int POWERUP_TIMER = 50;
  logic clk = 0, reset = 1, progModeExit = 0, swBrownoutEnableWr = 0, swBrownoutEnableIn = 1;
  logic sleepMode = 0, powerupTimerSel = 1, lowVoltageProgEnable = 0, pinResetEnable = 1;
  logic swPullupEnable = 1, watchdogTimeout = 0, watchdogClearInstr = 0, sleepInstr = 0;
  logic resetInstr = 0, stackErrorResetEnable = 1, stackOverflow = 0, stackUnderflow = 0;
  logic execViolation = 0, flagWr = 0, porReq = 1, dipReq = 0, pinLowReq = 0;
  logic [1:0] brownoutModeSel = BOR_MODE_ON;
  logic [7:0] flagWrData = 8'h00;
  logic porActive, detectorReady, supplyBelow, extResetPinIn, coreReset, brownoutDetectorOn;
  logic swBrownoutEnable, brownoutReady, pinPullupOn, pinResetFunction, extResetPinOe;
  logic brownoutCauseFlag, pinResetCauseFlag, instrResetCauseFlag, watchdogResetCauseFlag;
  logic stackOverflowFlag, stackUnderflowFlag, execViolationFlag, timeoutFlag, powerdownFlag;
  wire logic [8:0] flags = {stackOverflowFlag, stackUnderflowFlag, watchdogResetCauseFlag,
    pinResetCauseFlag, instrResetCauseFlag, execViolationFlag, brownoutCauseFlag, timeoutFlag,
    powerdownFlag};
  int err_total = 0;
  int tests_run = 0;
  rss_sequencer #(.POWERUP_TIMER_CYC(POWERUP_TIMER)) DUT (.*);
  rss_supply_model MODEL (.clk, .porReq, .dipReq, .pinLowReq, .detectorOn(brownoutDetectorOn),
    .pullupOn(pinPullupOn), .porActive, .detectorReady, .supplyBelow, .extResetPinIn);
  // 50 ns clock
  always #25 clk = ~clk;
  task automatic report_and_stop;
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chkb(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic [8:0] exp);
    tests_run++;
    if (flags !== exp) begin
      err_total++;
      $display("[ERR] %0t flags %h exp %h", $time, flags, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Count cycles until the core leaves reset, bounded
  task automatic wait_run(input int lim, output int n);
    n = 0;
    while (coreReset !== 1'b0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("[ERR] %0t core stuck %h exp %h", $time, coreReset, 1'b0);
      report_and_stop();
    end
  endtask
  // Software puts flags to idle; must never reset
  task automatic restore;
    flagWrData = 8'h1F;
    pulse(flagWr);
    pulse(watchdogClearInstr);
    cyc(2);
    chkf(9'h07F);
    chkb(coreReset, 1'b0);
  endtask
  task automatic sc_por;
    int n;
    cyc(4);
    porReq = 1'b0;
    wait_run(400, n);
    chkb(n >= POWERUP_TIMER + RELEASE_CYC, 1'b1);
    chkb(brownoutReady, 1'b1);
    chkf(9'h07B);
    chkb(swBrownoutEnable, 1'b1);
  endtask
  task automatic sc_pin;
    int n;
    swPullupEnable = 1'b0;
    pinResetEnable = 1'b0;
    cyc(6);
    chkb(pinResetFunction, 1'b0);
    chkb(pinPullupOn, 1'b0);
    chkb(coreReset, 1'b0);
    swPullupEnable = 1'b1;
    cyc(2);
    lowVoltageProgEnable = 1'b1;
    cyc(3);
    chkb(pinResetFunction, 1'b1);
    lowVoltageProgEnable = 1'b0;
    pinResetEnable = 1'b1;
    pinLowReq = 1'b1;
    cyc(2);
    pinLowReq = 1'b0;
    cyc(12);
    chkb(coreReset, 1'b0);
    pinLowReq = 1'b1;
    cyc(30);
    chkb(coreReset, 1'b1);
    chkf(9'h05F);
    pinLowReq = 1'b0;
    wait_run(40, n);
    chkb(n >= RELEASE_CYC, 1'b1);
    restore();
  endtask
  task automatic sc_warm;
    int n;
    logic [8:0] want [5] = '{9'h03D, 9'h06F, 9'h17F, 9'h0FF, 9'h077};
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: pulse(watchdogTimeout);
        1: pulse(resetInstr);
        2: pulse(stackOverflow);
        3: pulse(stackUnderflow);
        default: pulse(execViolation);
      endcase
      cyc(4);
      chkb(coreReset, 1'b1);
      chkf(want[k]);
      wait_run(40, n);
      restore();
    end
    // Sleep clears powerdown; a watchdog expiry in sleep wakes without reset
    pulse(sleepInstr);
    cyc(2);
    chkf(9'h07E);
    sleepMode = 1'b1;
    pulse(watchdogTimeout);
    cyc(4);
    chkb(coreReset, 1'b0);
    chkf(9'h07C);
    sleepMode = 1'b0;
    restore();
    stackErrorResetEnable = 1'b0;
    pulse(stackOverflow);
    cyc(4);
    chkb(coreReset, 1'b0);
    stackErrorResetEnable = 1'b1;
    flagWrData = 8'hC0;
    pulse(flagWr);
    cyc(3);
    chkb(coreReset, 1'b0);
    chkf(9'h183);
    restore();
  endtask
  task automatic sc_bor;
    int n;
    dipReq = 1'b1;
    cyc(10);
    dipReq = 1'b0;
    cyc(6);
    chkb(coreReset, 1'b0);
    dipReq = 1'b1;
    cyc(30);
    chkb(coreReset, 1'b1);
    chkf(9'h07B);
    dipReq = 1'b0;
    wait_run(400, n);
    chkb(n >= POWERUP_TIMER, 1'b1);
    restore();
  endtask
  task automatic sc_modes;
    brownoutModeSel = BOR_MODE_OFF;
    pulse(swBrownoutEnableWr);
    dipReq = 1'b1;
    cyc(30);
    dipReq = 1'b0;
    cyc(2);
    chkb(coreReset, 1'b0);
    chkb(brownoutDetectorOn, 1'b0);
    brownoutModeSel = BOR_MODE_SW;
    swBrownoutEnableIn = 1'b0;
    pulse(swBrownoutEnableWr);
    cyc(3);
    chkb(brownoutDetectorOn, 1'b0);
    swBrownoutEnableIn = 1'b1;
    pulse(swBrownoutEnableWr);
    sleepMode = 1'b1;
    cyc(14);
    chkb(brownoutDetectorOn, 1'b1);
    chkb(brownoutReady, 1'b1);
    brownoutModeSel = BOR_MODE_NOSLP;
    cyc(3);
    chkb(brownoutDetectorOn, 1'b0);
    chkb(brownoutReady, 1'b0);
    brownoutModeSel = BOR_MODE_ON;
    cyc(3);
    chkb(brownoutDetectorOn, 1'b1);
    sleepMode = 1'b0;
    cyc(12);
  endtask
  task automatic sc_progexit;
    int n;
    pinLowReq = 1'b1;
    pulse(progModeExit);
    cyc(2);
    chkb(coreReset, 1'b1);
    cyc(POWERUP_TIMER + 40);
    pinLowReq = 1'b0;
    wait_run(40, n);
    chkb(n >= RELEASE_CYC && n <= RELEASE_CYC + 10, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    sc_por();
    restore();
    sc_pin();
    sc_warm();
    sc_bor();
    sc_modes();
    sc_progexit();
    report_and_stop();
  end
endmodule
`default_nettype wire
